/* File: iebk_gate.sv */
// One enable word: stored enable bits, gated request forward, rise event.
// Assumes requests are synchronous levels from the peripherals.
`default_nettype none

module iebk_gate #(
	parameter logic [15:0] IMPL = 16'hFFFF,
	parameter logic [15:0] RST  = 16'h0000
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        wr_en,
	input  wire logic [15:0] wdata,
	input  wire logic [15:0] src_req,
	output logic      [15:0] en_q,
	output logic      [15:0] fwd_q,
	output logic             rise_q
);

	logic [15:0] en_r;
	logic [15:0] en_nxt;
	logic [15:0] fwd_r;
	logic [15:0] fwd_nxt;
	logic        rise_r;
	logic        rise_nxt;

	// Unimplemented bits never store, so they read zero
	always_comb begin
		en_nxt   = wr_en ? (wdata & IMPL) : en_r;
		fwd_nxt  = src_req & en_r;
		rise_nxt = |(fwd_nxt & ~fwd_r);
	end

	// Constants only under reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			en_r   <= RST;
			fwd_r  <= 16'h0000;
			rise_r <= 1'b0;
		end else begin
			en_r   <= en_nxt;
			fwd_r  <= fwd_nxt;
			rise_r <= rise_nxt;
		end
	end

	assign en_q   = en_r;
	assign fwd_q  = fwd_r;
	assign rise_q = rise_r;

endmodule : iebk_gate

`default_nettype wire

/* File: iebk_pkg.sv */
// Types shared by the interrupt enable bank modules.
// Assumes iebk_regs.svh holds all numeric constants.
`default_nettype none

package iebk_pkg;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	// Register port request, one strobe at a time
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        we;
		logic        re;
	} iebk_bus_t;

	// One request or enable vector per enable word
	typedef struct packed {
		logic [15:0] w2;
		logic [15:0] w3;
		logic [15:0] w4;
	} iebk_words_t;

endpackage : iebk_pkg

`default_nettype wire

/* File: iebk_regs.svh */
// Register offsets, field masks, reset values of the interrupt enable bank.
// Assumes inclusion by bare name from iebk_top and the bench.
`ifndef IEBK_REGS_SVH
`define IEBK_REGS_SVH

// ****************************************************************
// Byte offsets on the register port
// ****************************************************************
`define IEBK_OFF_WORD2    8'h00
`define IEBK_OFF_WORD3    8'h04
`define IEBK_OFF_WORD4    8'h08
`define IEBK_OFF_STATUS   8'h0C
`define IEBK_OFF_MASK     8'h10

// ****************************************************************
// Implemented bits of each enable word
// ****************************************************************
`define IEBK_IMPL_WORD2   16'h0007
`define IEBK_IMPL_WORD3   16'hA7FF
`define IEBK_IMPL_WORD4   16'h00F7

// ****************************************************************
// Field positions
// ****************************************************************
`define IEBK_W2_CAN1_RX_READY    2
`define IEBK_W2_SPI2_EVENT       1
`define IEBK_W2_SPI2_ERROR       0
`define IEBK_W3_PWM_FAULT_A      15
`define IEBK_W3_DMA_CH5_DONE     13
`define IEBK_W3_QUAD_ENCODER     10
`define IEBK_W3_PWM_ERROR        9
`define IEBK_W3_CAN2_EVENT       8
`define IEBK_W3_CAN2_RX_READY    7
`define IEBK_W3_EXT_IRQ4         6
`define IEBK_W3_EXT_IRQ3         5
`define IEBK_W3_TIMER9           4
`define IEBK_W3_TIMER8           3
`define IEBK_W3_I2C2_MASTER      2
`define IEBK_W3_I2C2_SLAVE       1
`define IEBK_W3_TIMER7           0
`define IEBK_W4_CAN2_TX_REQ      7
`define IEBK_W4_CAN1_TX_REQ      6
`define IEBK_W4_DMA_CH7_DONE     5
`define IEBK_W4_DMA_CH6_DONE     4
`define IEBK_W4_UART2_ERROR      2
`define IEBK_W4_UART1_ERROR      1
`define IEBK_W4_PWM_FAULT_B      0

// Status and mask bit per enable word
`define IEBK_EV_WORD2     0
`define IEBK_EV_WORD3     1
`define IEBK_EV_WORD4     2
`define IEBK_EV_IMPL      3'h7

// ****************************************************************
// Reset values
// ****************************************************************
`define IEBK_RST_WORD     16'h0000
`define IEBK_RST_EV       3'h0

`endif

/* File: iebk_src_model.sv */
// Peripheral source model: sticky request flags, one per enable bit.
// Assumes the bench pulses set and clear vectors for one clock each.
`default_nettype none

module iebk_src_model (
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire iebk_pkg::iebk_words_t set_req,
	input  wire iebk_pkg::iebk_words_t clr_req,
	output iebk_pkg::iebk_words_t      src_req
);
	timeunit 1ns;
	timeprecision 1ns;

	iebk_pkg::iebk_words_t flag_r;

	// Flags move on own events only; the bank has no path back here
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flag_r <= '0;
		end else begin
			flag_r <= (flag_r & ~clr_req) | set_req;
		end
	end

	assign src_req = flag_r;
endmodule : iebk_src_model

`default_nettype wire

/* File: iebk_top.sv */
// Interrupt enable bank: three enable words gating peripheral requests.
// Assumes synchronous request levels and a single-strobe register master.
`include "iebk_regs.svh"
`default_nettype none

module iebk_top (
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire iebk_pkg::iebk_bus_t bus,
	input  wire iebk_pkg::iebk_words_t src_req,
	output logic [31:0]              rdata,
	output iebk_pkg::iebk_words_t    fwd_req,
	output logic                     irq
);

	// ****************************************************************
	// Address decode
	// ****************************************************************
	logic                  wr_word2;
	logic                  wr_word3;
	logic                  wr_word4;
	logic                  wr_status;
	logic                  wr_mask;
	iebk_pkg::iebk_words_t en;
	iebk_pkg::iebk_words_t fwd;
	logic [2:0]            rise;

	// Write strobes per register
	always_comb begin
		wr_word2  = bus.we && (bus.addr == `IEBK_OFF_WORD2);
		wr_word3  = bus.we && (bus.addr == `IEBK_OFF_WORD3);
		wr_word4  = bus.we && (bus.addr == `IEBK_OFF_WORD4);
		wr_status = bus.we && (bus.addr == `IEBK_OFF_STATUS);
		wr_mask   = bus.we && (bus.addr == `IEBK_OFF_MASK);
	end

	// ****************************************************************
	// Enable words
	// ****************************************************************
	// Word2: only the low three bits live here, rest reads zero
	iebk_gate #(
		.IMPL (`IEBK_IMPL_WORD2),
		.RST  (`IEBK_RST_WORD)
	) u_word2 (
		.clk     (clk),
		.resetn  (resetn),
		.wr_en   (wr_word2),
		.wdata   (bus.wdata[15:0]),
		.src_req (src_req.w2),
		.en_q    (en.w2),
		.fwd_q   (fwd.w2),
		.rise_q  (rise[`IEBK_EV_WORD2])
	);

	// Word3: holes at bits 14, 12, 11
	iebk_gate #(
		.IMPL (`IEBK_IMPL_WORD3),
		.RST  (`IEBK_RST_WORD)
	) u_word3 (
		.clk     (clk),
		.resetn  (resetn),
		.wr_en   (wr_word3),
		.wdata   (bus.wdata[15:0]),
		.src_req (src_req.w3),
		.en_q    (en.w3),
		.fwd_q   (fwd.w3),
		.rise_q  (rise[`IEBK_EV_WORD3])
	);

	// Word4: upper byte and bit 3 are holes
	iebk_gate #(
		.IMPL (`IEBK_IMPL_WORD4),
		.RST  (`IEBK_RST_WORD)
	) u_word4 (
		.clk     (clk),
		.resetn  (resetn),
		.wr_en   (wr_word4),
		.wdata   (bus.wdata[15:0]),
		.src_req (src_req.w4),
		.en_q    (en.w4),
		.fwd_q   (fwd.w4),
		.rise_q  (rise[`IEBK_EV_WORD4])
	);

	// Forward path is output only: no line runs back to the sources
	assign fwd_req = fwd;

	// ****************************************************************
	// Event status, mask and interrupt line
	// ****************************************************************
	logic [2:0] status_r;
	logic [2:0] status_nxt;
	logic [2:0] mask_r;
	logic [2:0] mask_nxt;
	logic       irq_r;
	logic       irq_nxt;

	// A rise in the clearing cycle survives: set beats clear
	always_comb begin
		status_nxt = status_r;
		if (wr_status) begin
			status_nxt = status_r & ~bus.wdata[2:0];
		end
		status_nxt = status_nxt | rise;
		mask_nxt   = wr_mask ? (bus.wdata[2:0] & `IEBK_EV_IMPL) : mask_r;
		irq_nxt    = |(status_r & mask_r);
	end

	// Interrupt trails status by one cycle, kept so it is a flop
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_r <= `IEBK_RST_EV;
			mask_r   <= `IEBK_RST_EV;
			irq_r    <= 1'b0;
		end else begin
			status_r <= status_nxt;
			mask_r   <= mask_nxt;
			irq_r    <= irq_nxt;
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;

	// Data stand one cycle only, zero otherwise and for holes
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (bus.re) begin
			unique case (bus.addr)
				`IEBK_OFF_WORD2:  rdata_nxt = {16'h0000, en.w2};
				`IEBK_OFF_WORD3:  rdata_nxt = {16'h0000, en.w3};
				`IEBK_OFF_WORD4:  rdata_nxt = {16'h0000, en.w4};
				`IEBK_OFF_STATUS: rdata_nxt = {29'h0, status_r};
				`IEBK_OFF_MASK:   rdata_nxt = {29'h0, mask_r};
				default:          rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata = rdata_r;
	assign irq   = irq_r;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_word2_holes: assert property ((en.w2 & ~`IEBK_IMPL_WORD2) == 16'h0000)
		else $error("word2 hole bit set");

	a_word3_holes: assert property ((en.w3 & ~`IEBK_IMPL_WORD3) == 16'h0000)
		else $error("word3 hole bit set");

	a_word4_holes: assert property ((en.w4 & ~`IEBK_IMPL_WORD4) == 16'h0000)
		else $error("word4 hole bit set");

	a_fwd_word2: assert property (fwd.w2 == ($past(src_req.w2) & $past(en.w2)))
		else $error("word2 forward not gated by enable");

	a_fwd_word3: assert property (fwd.w3 == ($past(src_req.w3) & $past(en.w3)))
		else $error("word3 forward not gated by enable");

	a_fwd_word4: assert property (fwd.w4 == ($past(src_req.w4) & $past(en.w4)))
		else $error("word4 forward not gated by enable");

	a_write_word3: assert property (wr_word3 |=> en.w3 == ($past(bus.wdata[15:0]) & `IEBK_IMPL_WORD3))
		else $error("word3 write not stored");

	a_hold_word4: assert property (!wr_word4 |=> $stable(en.w4))
		else $error("word4 changed without write");

	a_read_word4: assert property (bus.re && bus.addr == `IEBK_OFF_WORD4 |=>
		rdata == {16'h0000, $past(en.w4)})
		else $error("word4 read data wrong");

	a_enable_path: assert property (wr_word3 && bus.wdata[15] ##1 src_req.w3[15] |=> fwd.w3[15])
		else $error("fault A not forwarded after enable");

	a_set_wins: assert property (rise[`IEBK_EV_WORD3] |=> status_r[`IEBK_EV_WORD3])
		else $error("word3 event lost");

	a_irq_follow: assert property (status_r[0] && mask_r[0] ##1 status_r[0] && mask_r[0]
		|-> irq)
		else $error("masked-in event without interrupt");

	// ****************************************************************
	// Per-field gating
	// ****************************************************************
	// A cleared enable bit must block its own source one cycle on; catches swapped lanes
	a_gate_spi2_err: assert property (!en.w2[`IEBK_W2_SPI2_ERROR] |=>
		!fwd.w2[`IEBK_W2_SPI2_ERROR])
		else $error("spi2 error passed while disabled");

	a_gate_spi2_ev: assert property (!en.w2[`IEBK_W2_SPI2_EVENT] |=>
		!fwd.w2[`IEBK_W2_SPI2_EVENT])
		else $error("spi2 event passed while disabled");

	a_gate_can1_rx: assert property (!en.w2[`IEBK_W2_CAN1_RX_READY] |=>
		!fwd.w2[`IEBK_W2_CAN1_RX_READY])
		else $error("can1 rx ready passed while disabled");

	a_gate_fault_a: assert property (!en.w3[`IEBK_W3_PWM_FAULT_A] |=>
		!fwd.w3[`IEBK_W3_PWM_FAULT_A])
		else $error("fault A passed while disabled");

	a_gate_dma5: assert property (!en.w3[`IEBK_W3_DMA_CH5_DONE] |=>
		!fwd.w3[`IEBK_W3_DMA_CH5_DONE])
		else $error("dma channel 5 passed while disabled");

	a_gate_encoder: assert property (!en.w3[`IEBK_W3_QUAD_ENCODER] |=>
		!fwd.w3[`IEBK_W3_QUAD_ENCODER])
		else $error("encoder event passed while disabled");

	a_gate_pwm_err: assert property (!en.w3[`IEBK_W3_PWM_ERROR] |=>
		!fwd.w3[`IEBK_W3_PWM_ERROR])
		else $error("pwm error passed while disabled");

	a_gate_can2_ev: assert property (!en.w3[`IEBK_W3_CAN2_EVENT] |=>
		!fwd.w3[`IEBK_W3_CAN2_EVENT])
		else $error("can2 event passed while disabled");

	a_gate_can2_rx: assert property (!en.w3[`IEBK_W3_CAN2_RX_READY] |=>
		!fwd.w3[`IEBK_W3_CAN2_RX_READY])
		else $error("can2 rx ready passed while disabled");

	a_gate_ext4: assert property (!en.w3[`IEBK_W3_EXT_IRQ4] |=>
		!fwd.w3[`IEBK_W3_EXT_IRQ4])
		else $error("external irq 4 passed while disabled");

	a_gate_ext3: assert property (!en.w3[`IEBK_W3_EXT_IRQ3] |=>
		!fwd.w3[`IEBK_W3_EXT_IRQ3])
		else $error("external irq 3 passed while disabled");

	a_gate_timer9: assert property (!en.w3[`IEBK_W3_TIMER9] |=>
		!fwd.w3[`IEBK_W3_TIMER9])
		else $error("timer 9 passed while disabled");

	a_gate_timer8: assert property (!en.w3[`IEBK_W3_TIMER8] |=>
		!fwd.w3[`IEBK_W3_TIMER8])
		else $error("timer 8 passed while disabled");

	a_gate_timer7: assert property (!en.w3[`IEBK_W3_TIMER7] |=>
		!fwd.w3[`IEBK_W3_TIMER7])
		else $error("timer 7 passed while disabled");

	a_gate_i2c2_mst: assert property (!en.w3[`IEBK_W3_I2C2_MASTER] |=>
		!fwd.w3[`IEBK_W3_I2C2_MASTER])
		else $error("i2c2 master event passed while disabled");

	a_gate_i2c2_slv: assert property (!en.w3[`IEBK_W3_I2C2_SLAVE] |=>
		!fwd.w3[`IEBK_W3_I2C2_SLAVE])
		else $error("i2c2 slave event passed while disabled");

	a_gate_can2_tx: assert property (!en.w4[`IEBK_W4_CAN2_TX_REQ] |=>
		!fwd.w4[`IEBK_W4_CAN2_TX_REQ])
		else $error("can2 tx request passed while disabled");

	a_gate_can1_tx: assert property (!en.w4[`IEBK_W4_CAN1_TX_REQ] |=>
		!fwd.w4[`IEBK_W4_CAN1_TX_REQ])
		else $error("can1 tx request passed while disabled");

	a_gate_dma7: assert property (!en.w4[`IEBK_W4_DMA_CH7_DONE] |=>
		!fwd.w4[`IEBK_W4_DMA_CH7_DONE])
		else $error("dma channel 7 passed while disabled");

	a_gate_dma6: assert property (!en.w4[`IEBK_W4_DMA_CH6_DONE] |=>
		!fwd.w4[`IEBK_W4_DMA_CH6_DONE])
		else $error("dma channel 6 passed while disabled");

	a_gate_uart2_err: assert property (!en.w4[`IEBK_W4_UART2_ERROR] |=>
		!fwd.w4[`IEBK_W4_UART2_ERROR])
		else $error("uart2 error passed while disabled");

	a_gate_uart1_err: assert property (!en.w4[`IEBK_W4_UART1_ERROR] |=>
		!fwd.w4[`IEBK_W4_UART1_ERROR])
		else $error("uart1 error passed while disabled");

	a_gate_fault_b: assert property (!en.w4[`IEBK_W4_PWM_FAULT_B] |=>
		!fwd.w4[`IEBK_W4_PWM_FAULT_B])
		else $error("fault B passed while disabled");

	c_read_word3: cover property (bus.re && bus.addr == `IEBK_OFF_WORD3 ##1 rdata != 32'h0);
	c_irq_raised: cover property (!irq ##1 irq);
	c_clear_race: cover property (wr_status && bus.wdata[1] && rise[`IEBK_EV_WORD3]);

endmodule : iebk_top

`default_nettype wire

/* File: test_interrupt_enable_bank.sv */
// Bench for the interrupt enable bank: register port tasks and sequences.
// Assumes the register map and implemented masks of iebk_regs.svh.
`include "iebk_regs.svh"
`default_nettype none

module test_interrupt_enable_bank;
	timeunit 1ns;
	timeprecision 1ns;

	logic                  clk;
	logic                  resetn;
	iebk_pkg::iebk_bus_t   bus;
	iebk_pkg::iebk_words_t set_req;
	iebk_pkg::iebk_words_t clr_req;
	iebk_pkg::iebk_words_t src_req;
	iebk_pkg::iebk_words_t fwd_req;
	logic [31:0]           rdata;
	logic                  irq;
	int                    err_total;
	int                    n_checks;
	logic [7:0]            offs [3];
	logic [15:0]           impl [3];
	logic [15:0]           bitv;

	iebk_top uut (
		.clk    (clk),
		.resetn (resetn),
		.bus    (bus),
		.src_req(src_req),
		.rdata  (rdata),
		.fwd_req(fwd_req),
		.irq    (irq)
	);

	iebk_src_model src_model (
		.clk    (clk),
		.resetn (resetn),
		.set_req(set_req),
		.clr_req(clr_req),
		.src_req(src_req)
	);

	// ****************************************************************
	// Clock and helpers
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	function automatic logic [15:0] word_of(iebk_pkg::iebk_words_t v, int k);
		return (k == 0) ? v.w2 : ((k == 1) ? v.w3 : v.w4);
	endfunction : word_of

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", what, exp, got);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge clk);
		bus.we <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		bus <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
		@(posedge clk);
		bus.re <= 1'b0;
		#1;
		chk("rdata", exp, rdata);
	endtask : chk_rd

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up

	// Hang guard well beyond the sequence length
	initial begin
		#400000;
		err_total++;
		wrap_up();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		offs = '{`IEBK_OFF_WORD2, `IEBK_OFF_WORD3, `IEBK_OFF_WORD4};
		impl = '{`IEBK_IMPL_WORD2, `IEBK_IMPL_WORD3, `IEBK_IMPL_WORD4};
		err_total = 0;
		n_checks = 0;
		resetn = 1'b0;
		bus = '0;
		set_req = '0;
		clr_req = '0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		// All registers clear after reset
		for (int k = 0; k < 5; k++) begin
			chk_rd(8'(4 * k), 32'h0);
		end
		// Holes and upper bits read zero, implemented bits keep ones
		for (int k = 0; k < 3; k++) begin
			wr(offs[k], 32'hFFFF_FFFF);
			chk_rd(offs[k], {16'h0, impl[k]});
		end
		// Unmapped place ignores writes and reads zero
		wr(8'h14, 32'hFFFF_FFFF);
		chk_rd(8'h14, 32'h0);
		// Raise every source, then walk a single enable bit per word
		@(posedge clk);
		set_req <= '1;
		@(posedge clk);
		set_req <= '0;
		tick(3);
		for (int k = 0; k < 3; k++) begin
			chk("fwd", {16'h0, impl[k]}, {16'h0, word_of(fwd_req, k)});
		end
		for (int k = 0; k < 3; k++) begin
			for (int b = 0; b < 16; b++) begin
				bitv = 16'h1 << b;
				wr(offs[k], {16'h0, bitv});
				tick(2);
				chk("fwd", {16'h0, bitv & impl[k]}, {16'h0, word_of(fwd_req, k)});
				chk("src", 32'h0000_FFFF, {16'h0, word_of(src_req, k)});
			end
		end
		// Interrupt: clear, mask, raise, mask off, clear again
		wr(`IEBK_OFF_STATUS, 32'h7);
		wr(`IEBK_OFF_MASK, 32'h7);
		tick(3);
		chk("irq", 32'h0, {31'h0, irq});
		wr(`IEBK_OFF_WORD3, 32'h0);
		tick(2);
		wr(`IEBK_OFF_WORD3, 32'h2000);
		tick(4);
		chk("irq", 32'h1, {31'h0, irq});
		chk_rd(`IEBK_OFF_STATUS, 32'h2);
		wr(`IEBK_OFF_MASK, 32'h5);
		tick(3);
		chk("irq", 32'h0, {31'h0, irq});
		wr(`IEBK_OFF_STATUS, 32'h2);
		tick(3);
		chk_rd(`IEBK_OFF_STATUS, 32'h0);
		// Word2 event through mask bit 0
		wr(`IEBK_OFF_WORD2, 32'h1);
		tick(4);
		chk("irq", 32'h1, {31'h0, irq});
		chk_rd(`IEBK_OFF_STATUS, 32'h1);
		// Source drops: forward follows even while enabled
		@(posedge clk);
		clr_req <= '1;
		@(posedge clk);
		clr_req <= '0;
		tick(3);
		chk("fwd", 32'h0, {16'h0, fwd_req.w3});
		chk("irq", 32'h1, {31'h0, irq});
		// Second reset mid-run: written enables return to zero and irq drops
		wr(`IEBK_OFF_WORD4, 32'hFFFF_FFFF);
		@(posedge clk);
		resetn <= 1'b0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			chk_rd(offs[k], 32'h0);
		end
		chk("irq", 32'h0, {31'h0, irq});
		wrap_up();
	end
endmodule : test_interrupt_enable_bank

`default_nettype wire
